// File: hw/mhbe_pkg.sv
// Purpose: shared types and constants for the multiplexed host bus emulation
// Assumes: 40 MHz system clock
// Notes:   instruction codes are local encodings of the command port
package mhbe_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    // command opcodes on the host command port
    localparam logic [2:0] OP_WRITE     = 3'h0;
    localparam logic [2:0] OP_READ      = 3'h1;
    localparam logic [2:0] OP_SET_HIGH  = 3'h2;
    localparam logic [2:0] OP_READ_HIGH = 3'h3;
    localparam logic [2:0] OP_WAIT_HI   = 3'h4;
    localparam logic [2:0] OP_WAIT_LO   = 3'h5;
    // bit positions inside the high byte
    localparam int AUX0_BIT = 0;
    localparam int AUX1_BIT = 1;
    // reset values
    localparam logic [7:0]  HIGH_RST    = 8'h00;
    localparam logic [7:0]  HIGH_DIR_RST = 8'h00;
    // phase timing in system cycles
    localparam int ALE_CYCLES   = 2;
    localparam int STROBE_CYCLES = 2;
    // synchroniser stages; a pin change needs four edges before the filtered level follows it
    localparam int WAIT_SYNC_CYCLES = 3;
    localparam int CLK_DIV_DEFAULT = 4;

    typedef enum {
        ST_IDLE, ST_CS, ST_ALE, ST_ADDR_HOLD, ST_STROBE, ST_RELEASE, ST_CS_OFF, ST_WAIT_IRQ
    } mhbe_state_t;

    typedef struct packed {
        logic              valid;
        logic [2:0]        op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [DATA_W-1:0] mask;
    } mhbe_cmd_t;

    typedef struct packed {
        logic              valid;
        logic [DATA_W-1:0] data;
    } mhbe_rsp_t;

    typedef struct packed {
        logic [DATA_W-1:0] ad_out;
        logic              ad_oe;
        logic [7:0]        addr_high;
        logic              cs_n;
        logic              ale;
        logic              rd_n;
        logic              wr_n;
        logic              clk_out;
    } mhbe_bus_t;
endpackage

// File: hw/mhbe_core.sv
// Purpose: bus master imitating a classic 8-bit MCU multiplexed external bus
// Assumes: host commands arrive on the same clock; peripheral pins are asynchronous
// Notes:   one command at a time; cmd_ready shows when the next may be given
// Functional notes
// RULE1: one muxed bus, address then data
// RULE2: upper address on eight dedicated lines
// RULE3: select low during each access only
// RULE4: latch pulse while address on bus
// RULE5: read strobe low, peripheral drives data
// RULE6: write data stable around write strobe
// RULE7: wait input low stretches the access
// RULE8: clock output follows interface clock
// RULE9: high byte commands drive/sample aux zero
// RULE10: wait on aux level, then read
// RULE11: aux wait line kept as input
// RULE12: mode enabled only with channels combined
// RULE13: select, latch, strobe, release in order
`timescale 1ns/1ps
module mhbe_core #(
    parameter int CLK_DIV = mhbe_pkg::CLK_DIV_DEFAULT
) (
    input  wire logic                      clk,
    input  wire logic                      sys_rst,
    input  wire logic                      channels_combined,
    input  wire mhbe_pkg::mhbe_cmd_t       cmd,
    output logic                           cmd_ready,
    output mhbe_pkg::mhbe_rsp_t            rsp,
    input  wire logic [7:0]                muxed_addr_data_bus_in,
    output logic [7:0]                     muxed_addr_data_bus_out,
    output logic                           muxed_addr_data_bus_oe,
    output logic [7:0]                     addr_high,
    output logic                           periph_select_n,
    output logic                           addr_latch_en,
    output logic                           read_strobe_n,
    output logic                           write_strobe_n,
    input  wire logic                      wait_extend_input,
    output logic                           interface_clock_out,
    input  wire logic                      aux_line_zero_in,
    output logic                           aux_line_zero_out,
    output logic                           aux_line_zero_oe,
    input  wire logic                      aux_line_wait_in,
    output logic                           aux_line_wait_out,
    output logic                           aux_line_wait_oe
);
    typedef struct packed {
        mhbe_pkg::mhbe_state_t st;
        logic [2:0]            op;
        logic [15:0]           addr;
        logic [7:0]            wdata;
        logic [3:0]            cnt;
        logic [7:0]            div;
        logic                  clk_q;
        logic [2:0]            wait_sync;
        logic                  wait_ok;
        logic [2:0]            aux0_sync;
        logic [2:0]            aux1_sync;
        logic                  aux0_val;
        logic                  aux1_val;
        logic [7:0]            high_val;
        logic [7:0]            high_dir;
        logic                  ready;
        mhbe_pkg::mhbe_rsp_t   rsp;
        mhbe_pkg::mhbe_bus_t   bus;
    } mhbe_core_state_t;

    mhbe_core_state_t r;
    mhbe_core_state_t next_r;

    // second and third stage agree before a level change is accepted
    function automatic logic mhbe_filt(input logic [2:0] s, input logic old);
        mhbe_filt = (s[2] == s[1]) ? s[1] : old;
    endfunction

    always_comb begin
        next_r = r;
        next_r.rsp.valid = 1'b0;
        next_r.wait_sync = {r.wait_sync[1:0], wait_extend_input};
        next_r.aux0_sync = {r.aux0_sync[1:0], aux_line_zero_in};
        next_r.aux1_sync = {r.aux1_sync[1:0], aux_line_wait_in};
        next_r.wait_ok  = mhbe_filt(r.wait_sync, r.wait_ok);
        next_r.aux0_val = mhbe_filt(r.aux0_sync, r.aux0_val);
        next_r.aux1_val = mhbe_filt(r.aux1_sync, r.aux1_val);
        // RULE8: interface clock divider
        if (r.div == 8'(CLK_DIV - 1)) begin
            next_r.div   = 8'h00;
            next_r.clk_q = ~r.clk_q;
        end else begin
            next_r.div = r.div + 8'h01;
        end
        next_r.bus.clk_out = r.clk_q;
        // RULE11: aux wait line never driven
        next_r.high_dir[mhbe_pkg::AUX1_BIT] = 1'b0;
        case (r.st)
            mhbe_pkg::ST_IDLE: begin
                next_r.ready = channels_combined;
                // RULE12: only with combined channels
                if (cmd.valid && r.ready && channels_combined) begin
                    next_r.ready = 1'b0;
                    next_r.op    = cmd.op;
                    next_r.addr  = cmd.addr;
                    next_r.wdata = cmd.data;
                    case (cmd.op)
                        mhbe_pkg::OP_WRITE, mhbe_pkg::OP_READ: begin
                            next_r.st = mhbe_pkg::ST_CS;
                        end
                        // RULE9: set or clear high byte
                        mhbe_pkg::OP_SET_HIGH: begin
                            next_r.high_val = cmd.data;
                            next_r.high_dir = cmd.mask & ~8'h02;
                            next_r.st       = mhbe_pkg::ST_CS_OFF;
                        end
                        // RULE9: sample high byte
                        mhbe_pkg::OP_READ_HIGH: begin
                            next_r.rsp.valid = 1'b1;
                            next_r.rsp.data  = {r.high_val[7:2], r.aux1_val, r.aux0_val};
                            next_r.st        = mhbe_pkg::ST_CS_OFF;
                        end
                        mhbe_pkg::OP_WAIT_HI, mhbe_pkg::OP_WAIT_LO: begin
                            next_r.st = mhbe_pkg::ST_WAIT_IRQ;
                        end
                        default: begin
                            next_r.st = mhbe_pkg::ST_CS_OFF;
                        end
                    endcase
                end
            end
            // RULE10: hold until aux level seen
            mhbe_pkg::ST_WAIT_IRQ: begin
                if (r.aux1_val == (r.op == mhbe_pkg::OP_WAIT_HI)) begin
                    next_r.op = mhbe_pkg::OP_READ;
                    next_r.st = mhbe_pkg::ST_CS;
                end
            end
            // RULE13: select first
            mhbe_pkg::ST_CS: begin
                // RULE3: select asserted
                next_r.bus.cs_n      = 1'b0;
                // RULE2: upper address out
                next_r.bus.addr_high = r.addr[15:8];
                // RULE1: address phase
                next_r.bus.ad_out = r.addr[7:0];
                next_r.bus.ad_oe  = 1'b1;
                next_r.cnt        = 4'h0;
                next_r.st         = mhbe_pkg::ST_ALE;
            end
            // RULE4: latch pulse
            mhbe_pkg::ST_ALE: begin
                next_r.bus.ale = 1'b1;
                next_r.cnt     = r.cnt + 4'h1;
                // cnt reaches ALE_CYCLES after that many cycles of latch high
                if (r.cnt == 4'(mhbe_pkg::ALE_CYCLES)) begin
                    next_r.bus.ale = 1'b0;
                    next_r.st      = mhbe_pkg::ST_ADDR_HOLD;
                end
            end
            mhbe_pkg::ST_ADDR_HOLD: begin
                next_r.cnt = 4'h0;
                if (r.op == mhbe_pkg::OP_WRITE) begin
                    // RULE6: data before strobe falls
                    next_r.bus.ad_out = r.wdata;
                end else begin
                    // RULE5: release bus for peripheral
                    next_r.bus.ad_oe = 1'b0;
                end
                next_r.st = mhbe_pkg::ST_STROBE;
            end
            mhbe_pkg::ST_STROBE: begin
                next_r.bus.rd_n = (r.op != mhbe_pkg::OP_READ);
                next_r.bus.wr_n = (r.op != mhbe_pkg::OP_WRITE);
                // strobe outlasts the synchroniser so a wait raised in answer is seen
                if (r.cnt != 4'(mhbe_pkg::STROBE_CYCLES + mhbe_pkg::WAIT_SYNC_CYCLES)) begin
                    next_r.cnt = r.cnt + 4'h1;
                // RULE7: stretch while wait low
                end else if (r.wait_ok) begin
                    next_r.st = mhbe_pkg::ST_RELEASE;
                end
            end
            mhbe_pkg::ST_RELEASE: begin
                // RULE5: capture read data at strobe rise
                if (r.op == mhbe_pkg::OP_READ) begin
                    next_r.rsp.valid = 1'b1;
                    next_r.rsp.data  = muxed_addr_data_bus_in;
                end
                next_r.bus.rd_n = 1'b1;
                next_r.bus.wr_n = 1'b1;
                next_r.st       = mhbe_pkg::ST_CS_OFF;
            end
            // RULE13: select released after strobe
            mhbe_pkg::ST_CS_OFF: begin
                // RULE6: data held past strobe rise
                next_r.bus.cs_n  = 1'b1;
                next_r.bus.ad_oe = 1'b0;
                next_r.st        = mhbe_pkg::ST_IDLE;
            end
            default: begin
                next_r.st = mhbe_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            r              <= '0;
            r.st           <= mhbe_pkg::ST_IDLE;
            r.high_val     <= mhbe_pkg::HIGH_RST;
            r.high_dir     <= mhbe_pkg::HIGH_DIR_RST;
            r.wait_sync    <= 3'h7;
            r.wait_ok      <= 1'b1;
            r.bus.cs_n     <= 1'b1;
            r.bus.rd_n     <= 1'b1;
            r.bus.wr_n     <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign cmd_ready               = r.ready;
    assign rsp                     = r.rsp;
    assign muxed_addr_data_bus_out = r.bus.ad_out;
    assign muxed_addr_data_bus_oe  = r.bus.ad_oe;
    assign addr_high               = r.bus.addr_high;
    assign periph_select_n         = r.bus.cs_n;
    assign addr_latch_en           = r.bus.ale;
    assign read_strobe_n           = r.bus.rd_n;
    assign write_strobe_n          = r.bus.wr_n;
    assign interface_clock_out     = r.bus.clk_out;
    assign aux_line_zero_out       = r.high_val[mhbe_pkg::AUX0_BIT];
    assign aux_line_zero_oe        = r.high_dir[mhbe_pkg::AUX0_BIT];
    assign aux_line_wait_out       = r.high_val[mhbe_pkg::AUX1_BIT];
    assign aux_line_wait_oe        = r.high_dir[mhbe_pkg::AUX1_BIT];
endmodule

// File: testbench/mhbe_core_monitor.sv
// Purpose: bus timing checker bound to mhbe_core
// Assumes: one clock domain, synchronous reset
// Notes:   wait input must stay low 5 cycles to get past the synchroniser
`timescale 1ns/1ps
module mhbe_core_monitor (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       channels_combined,
    input wire logic       cmd_ready,
    input wire logic [7:0] muxed_addr_data_bus_out,
    input wire logic       muxed_addr_data_bus_oe,
    input wire logic [7:0] addr_high,
    input wire logic       periph_select_n,
    input wire logic       addr_latch_en,
    input wire logic       read_strobe_n,
    input wire logic       write_strobe_n,
    input wire logic       wait_extend_input,
    input wire logic       aux_line_wait_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic strobe;
    assign strobe = !(read_strobe_n && write_strobe_n);
    sel_idle_a: assert property (periph_select_n |-> !strobe && !addr_latch_en)
        else $error("strobe or latch outside select");
    ale_pulse_a: assert property ($rose(addr_latch_en) |=> addr_latch_en ##1 !addr_latch_en)
        else $error("latch pulse not two cycles");
    ale_addr_a: assert property (addr_latch_en |-> muxed_addr_data_bus_oe && !periph_select_n)
        else $error("latch pulse without address driven");
    wr_setup_a: assert property (!write_strobe_n |-> muxed_addr_data_bus_oe
        && $stable(muxed_addr_data_bus_out))
        else $error("write data moved under strobe");
    wr_hold_a: assert property ($rose(write_strobe_n) |-> muxed_addr_data_bus_oe
        && $stable(muxed_addr_data_bus_out))
        else $error("write data not held after strobe");
    rd_float_a: assert property (!read_strobe_n |-> !muxed_addr_data_bus_oe)
        else $error("bus driven during read strobe");
    upper_hold_a: assert property (!periph_select_n && !$fell(periph_select_n)
        |-> $stable(addr_high))
        else $error("upper address moved in access");
    cs_first_a: assert property ($fell(periph_select_n) |=> addr_latch_en)
        else $error("latch did not follow select");
    cs_last_a: assert property ($rose(periph_select_n) |-> !$past(strobe))
        else $error("select released with strobe low");
    wait_hold_a: assert property ((!wait_extend_input) [*5] ##0 strobe |=> strobe)
        else $error("strobe ended while wait low");
    aux_input_a: assert property (!aux_line_wait_oe)
        else $error("aux wait line driven");
    mode_off_a: assert property (!channels_combined |=> !cmd_ready)
        else $error("ready while channels split");
    cover property ($rose(write_strobe_n));
    cover property ($rose(read_strobe_n));
    cover property ((!wait_extend_input) [*5] ##0 strobe);
endmodule
bind mhbe_core mhbe_core_monitor u_mon (
    .clk                     (clk),
    .sys_rst                 (sys_rst),
    .channels_combined       (channels_combined),
    .cmd_ready               (cmd_ready),
    .muxed_addr_data_bus_out (muxed_addr_data_bus_out),
    .muxed_addr_data_bus_oe  (muxed_addr_data_bus_oe),
    .addr_high               (addr_high),
    .periph_select_n         (periph_select_n),
    .addr_latch_en           (addr_latch_en),
    .read_strobe_n           (read_strobe_n),
    .write_strobe_n          (write_strobe_n),
    .wait_extend_input       (wait_extend_input),
    .aux_line_wait_oe        (aux_line_wait_oe)
);

// File: testbench/mhbe_periph_model.sv
// Purpose: peripheral chip on the multiplexed bus
// Assumes: address latched from the bus while latch enable is high
// Notes:   stall sets how many strobe cycles the wait line is held low
`timescale 1ns/1ps
module mhbe_periph_model (
    input  wire logic       clk,
    input  wire logic [7:0] bus,
    input  wire logic       select_n,
    input  wire logic       latch_en,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    input  wire logic [7:0] stall,
    output logic [7:0]      drive,
    output logic            drive_en,
    output logic            ready
);
    logic [7:0] mem [256];
    logic [7:0] addr;
    int         cnt = 0;
    always @(posedge clk) begin
        if (latch_en) addr <= bus;
        if (!select_n && !wr_n) mem[addr] <= bus;
        cnt <= (rd_n && wr_n) ? 0 : cnt + 1;
    end
    assign ready = (rd_n && wr_n) || cnt >= int'(stall);
    assign drive_en = !select_n && !rd_n;
    assign drive = mem[addr];
endmodule

// File: testbench/test_mhbe_core.sv
// Purpose: self-checking bench for mhbe_core
// Assumes: released bus sits at pull-up level; released aux zero pin reads aux0, which starts low
// Notes:   one task per scenario
`timescale 1ns/1ps
module test_mhbe_core;
    localparam int DIV = 4;
    logic                clk = 1'b0, sys_rst = 1'b1, comb = 1'b1, aux0 = 1'b0, aux1 = 1'b0;
    logic [7:0]          stall = 8'h00;
    mhbe_pkg::mhbe_cmd_t cmd = '0;
    mhbe_pkg::mhbe_rsp_t rsp;
    logic [7:0]          ad_in, ad_out, ah, drv;
    logic                oe, cs_n, ale, rd_n, wr_n, rdy, ck, z_out, z_oe, w_out, w_oe, ready, drv_en;
    int                  n_fail = 0, comparisons = 0;
    int                  st_len = 0, last_len = 0;
    assign ad_in = oe ? ad_out : drv_en ? drv : 8'hFF;
    mhbe_core #(.CLK_DIV(DIV)) dut (.clk(clk), .sys_rst(sys_rst), .channels_combined(comb),
        .cmd(cmd), .cmd_ready(ready), .rsp(rsp), .muxed_addr_data_bus_in(ad_in),
        .muxed_addr_data_bus_out(ad_out), .muxed_addr_data_bus_oe(oe), .addr_high(ah),
        .periph_select_n(cs_n), .addr_latch_en(ale), .read_strobe_n(rd_n),
        .write_strobe_n(wr_n), .wait_extend_input(rdy), .interface_clock_out(ck),
        .aux_line_zero_in(z_oe ? z_out : aux0), .aux_line_zero_out(z_out),
        .aux_line_zero_oe(z_oe), .aux_line_wait_in(aux1), .aux_line_wait_out(w_out),
        .aux_line_wait_oe(w_oe));
    mhbe_periph_model peri (.clk(clk), .bus(ad_in), .select_n(cs_n), .latch_en(ale),
        .rd_n(rd_n), .wr_n(wr_n), .stall(stall), .drive(drv), .drive_en(drv_en), .ready(rdy));
    initial forever #12.5 clk = ~clk;
    // length in cycles of the last read or write strobe
    always @(posedge clk) begin
        if (!rd_n || !wr_n) begin
            st_len <= st_len + 1;
        end else if (st_len != 0) begin
            last_len <= st_len;
            st_len   <= 0;
        end
    end
    task automatic check(string nm, logic [7:0] e, logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic issue(logic [2:0] op, logic [15:0] a, logic [7:0] d, logic [7:0] m);
        @(negedge clk);
        for (int k = 0; k < 500 && ready !== 1'b1; k++) @(negedge clk);
        // spacing of two cycles after ready returns
        repeat (2) @(negedge clk);
        cmd <= '{1'b1, op, a, d, m};
        @(negedge clk);
        cmd.valid <= 1'b0;
    endtask
    task automatic expect_rsp(string nm, logic [7:0] e, logic [7:0] m);
        for (int k = 0; k < 300 && rsp.valid !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        check(nm, e, (rsp.valid === 1'b1) ? rsp.data & m : 8'hXX);
    endtask
    task automatic t_rw();
        issue(mhbe_pkg::OP_WRITE, 16'h12A5, 8'h3C, 8'h00);
        stall <= 8'h06;
        issue(mhbe_pkg::OP_WRITE, 16'h3401, 8'hC3, 8'h00);
        issue(mhbe_pkg::OP_READ, 16'h3401, 8'h00, 8'h00);
        expect_rsp("stretched read", 8'hC3, 8'hFF);
        check("upper address", 8'h34, ah);
        repeat (2) @(negedge clk);
        check("strobe stretched", 8'h01, {7'h00, last_len > int'(stall)});
        stall <= 8'h00;
        issue(mhbe_pkg::OP_READ, 16'h12A5, 8'h00, 8'h00);
        expect_rsp("plain read", 8'h3C, 8'hFF);
    endtask
    task automatic t_aux();
        issue(mhbe_pkg::OP_SET_HIGH, 16'h0000, 8'h03, 8'h03);
        repeat (2) @(negedge clk);
        check("aux drive", 8'h03, {5'h00, w_oe, z_oe, z_out});
        issue(mhbe_pkg::OP_SET_HIGH, 16'h0000, 8'h00, 8'h00);
        aux1 <= 1'b1;
        repeat (4) @(negedge clk);
        issue(mhbe_pkg::OP_READ_HIGH, 16'h0000, 8'h00, 8'h00);
        expect_rsp("aux sample", 8'h02, 8'h03);
    endtask
    task automatic t_wait();
        for (int i = 0; i < 2; i++) begin
            @(negedge clk);
            aux1 <= i[0];
            repeat (5) @(negedge clk);
            issue(i ? mhbe_pkg::OP_WAIT_LO : mhbe_pkg::OP_WAIT_HI, 16'h12A5, 8'h00, 8'h00);
            repeat (20) @(negedge clk);
            check("idle while waiting", 8'h01, {7'h00, cs_n});
            aux1 <= !i[0];
            expect_rsp("read after wait", 8'h3C, 8'hFF);
        end
    endtask
    task automatic t_mode();
        @(negedge clk);
        comb <= 1'b0;
        cmd <= '{1'b1, mhbe_pkg::OP_WRITE, 16'h0000, 8'h55, 8'h00};
        repeat (10) @(negedge clk);
        check("split refuses", 8'h01, {6'h00, ready, cs_n});
        cmd.valid <= 1'b0;
        comb <= 1'b1;
    endtask
    task automatic t_clk();
        int   n;
        logic last;
        n = 0;
        @(negedge clk);
        last = ck;
        repeat (8 * DIV) begin
            @(negedge clk);
            if (ck !== last) n++;
            last = ck;
        end
        check("clock out edges", 8'h08, n[7:0]);
    endtask
    task automatic conclude();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge clk);
        sys_rst <= 1'b0;
        t_rw();
        t_aux();
        t_wait();
        t_mode();
        t_clk();
        conclude();
    end
    // whole run needs far fewer than 8000 cycles
    initial begin
        #200us;
        n_fail++;
        conclude();
    end
endmodule
